// >>> hw/rpcb_regs.vh
// Register map, field positions, reset values and timing counts
// Operation
// RULE1: Field-off register, default 0x0A, gives field-off time in ms.
// RULE2: Recovery register, default 0x25, gives wait after field on in ms.
// RULE3: Select, continuous read and multi-tag apply field-off and recovery.
// RULE4: Nonzero family filter is sent so only matching tags answer.
// RULE5: Family filter applies only to type B and vicinity tags.
// RULE6: Type A select time-out, default 0x10, slices of about 300 us.
// RULE7: Type B select time-out, default 0x10, slices of about 300 us.
// RULE8: Short-range tag select time-out, default 0x10, 300 us slices.
// RULE9: Vicinity tag select time-out, default 0x10, about 9.6 ms; the code counts 300 us slices, so 4.8 ms at default.
// RULE10: Config three bit 0 replaces automatic time-outs by the RF pair; the sequencer ignores it, select operations keep per-tag time-outs.
// RULE11: Config three bit 2 makes continuous read return tag memory.
// RULE12: Bits 3,4,5 ignore missing start, guard error, missing end.
// RULE13: Config three bit 6 puts two-byte request answer in extended ID.
// RULE14: Config three bit 7 appends select acknowledge byte to ID.
// RULE15: Threshold upper nibble is min signal, lower nibble collision level.
// RULE16: Config four bit 0 skips write read-back, acknowledge is 0x00.
// RULE17: Config four bit 1 uses wake-up instead of request commands.
// RULE18: Config four bit 2 appends card number to high-speed select.
// RULE19: Config four bit 3 drops option and length bytes in transfers.
// RULE20: Host keeps card logical number zero for single-tag use.
// RULE21: Guard wait in bit-clock cycles; zero selects predefined timing.
// RULE22: Four conductance registers; register zero is selected by default.
// RULE23: Reserved configuration bits read zero and do nothing.
`ifndef RPCB_REGS_VH
`define RPCB_REGS_VH

`define RPCB_OFF_FIELD_OFF      8'h14
`define RPCB_OFF_RECOVERY       8'h15
`define RPCB_OFF_FAMILY         8'h16
`define RPCB_OFF_TMO_A          8'h17
`define RPCB_OFF_TMO_B          8'h18
`define RPCB_OFF_TMO_SR         8'h19
`define RPCB_OFF_TMO_V          8'h1A
`define RPCB_OFF_CFG3           8'h1B
`define RPCB_OFF_PAGE_START     8'h1C
`define RPCB_OFF_COND0          8'h1D
`define RPCB_OFF_THRESH         8'h1E
`define RPCB_OFF_PAGE_COUNT     8'h1F
`define RPCB_OFF_CFG4           8'h20
`define RPCB_OFF_CARD_NUM       8'h21
`define RPCB_OFF_GUARD_WAIT     8'h22
`define RPCB_OFF_COND1          8'h23
`define RPCB_OFF_COND2          8'h24
`define RPCB_OFF_COND3          8'h25
`define RPCB_OFF_USER_LO        8'h80
`define RPCB_OFF_USER_HI        8'hEF
`define RPCB_OFF_TMR_LO         8'h10
`define RPCB_OFF_TMR_HI         8'h11

`define RPCB_RST_FIELD_OFF      8'h0A
`define RPCB_RST_RECOVERY       8'h25
`define RPCB_RST_FAMILY         8'h00
`define RPCB_RST_TMO            8'h10
`define RPCB_RST_CFG            8'h00
`define RPCB_RST_COND0          8'h05
`define RPCB_RST_COND_N         8'h00
`define RPCB_RST_THRESH         8'hEB
`define RPCB_RST_TMR            16'h0300

`define RPCB_CFG3_MASK          8'hFD
`define RPCB_CFG4_MASK          8'h0F
`define RPCB_C3_NO_AUTO_TMO     0
`define RPCB_C3_PAGE_READ       2
`define RPCB_C3_NO_RX_SOF       3
`define RPCB_C3_NO_RX_EGT       4
`define RPCB_C3_NO_RX_EOF       5
`define RPCB_C3_REQ_EXT_ID      6
`define RPCB_C3_SAK_EXT_ID      7
`define RPCB_C4_NO_READBACK     0
`define RPCB_C4_WAKEUP          1
`define RPCB_C4_CARD_EXT_ID     2
`define RPCB_C4_HUGE_DATA       3

`define RPCB_CLK_HZ             40000000
`define RPCB_MS_CYC             (`RPCB_CLK_HZ / 1000)
`define RPCB_SLICE_NS           300000
`define RPCB_SLICE_CYC          (`RPCB_SLICE_NS / 25)
`define RPCB_BITCLK_NS          9400
`define RPCB_BITCLK_CYC         (`RPCB_BITCLK_NS / 25)

`define RPCB_OP_SELECT          3'd0
`define RPCB_OP_HS_SELECT       3'd1
`define RPCB_OP_CONT_READ       3'd2
`define RPCB_OP_MULTI_LIST      3'd3
`define RPCB_OP_MULTI_SEL       3'd4
`define RPCB_OP_LOGIN           3'd5
`define RPCB_OP_OTHER           3'd7

`define RPCB_TAG_A              3'd0
`define RPCB_TAG_B              3'd1
`define RPCB_TAG_SR             3'd2
`define RPCB_TAG_V              3'd3

`endif

// >>> hw/rpcb_bank.v
// Reader protocol configuration bank with field reset and time-out engine
`timescale 1ns/1ps
`include "rpcb_regs.vh"

module rpcb_bank #(
	parameter MS_CYC    = `RPCB_MS_CYC,
	parameter SLICE_CYC = `RPCB_SLICE_CYC
) (
	// Clock and reset
	input  wire       clk,
	input  wire       rstn,
	// Register port
	input  wire       reg_wr,
	input  wire       reg_rd,
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	output reg  [7:0] reg_rdata,
	output reg        reg_rvalid,
	// Operation request
	input  wire       op_start,
	input  wire [2:0] op_code,
	input  wire [2:0] op_tag,
	input  wire       op_rx_done,
	input  wire [1:0] cond_sel,
	output reg        op_busy,
	output reg        op_timeout,
	output reg        op_done,
	// Field and receiver controls
	output reg        field_on,
	output reg        rx_enable,
	output reg        family_enable,
	output reg  [7:0] family_value,
	output reg  [3:0] min_signal_level,
	output reg  [3:0] collision_level,
	output reg  [7:0] drive_conductance,
	output reg  [7:0] guard_wait_cycles,
	output reg        guard_predefined,
	// Protocol flags
	output reg        rf_timeout_override,
	output reg        cont_read_memory,
	output reg  [7:0] page_start,
	output reg  [7:0] page_count,
	output reg        ignore_missing_rx_start,
	output reg        ignore_rx_guard_error,
	output reg        ignore_missing_rx_end,
	output reg        ext_id_request_answer,
	output reg        ext_id_append_sak,
	output reg        skip_write_readback,
	output reg        use_wakeup,
	output reg        hs_select_append_card,
	output reg        transfer_huge_data,
	output reg  [7:0] card_logical_number
);

	////////////////////////////////////////////////////////////////////////
	localparam ST_IDLE = 5'b00001;
	localparam ST_OFF  = 5'b00010;
	localparam ST_REC  = 5'b00100;
	localparam ST_COMM = 5'b01000;
	localparam ST_DONE = 5'b10000;
	reg [7:0]  field_off_duration;
	reg [7:0]  field_recovery_duration;
	reg [7:0]  application_family_filter;
	reg [7:0]  select_timeout_type_a;
	reg [7:0]  select_timeout_type_b;
	reg [7:0]  select_timeout_short_range;
	reg [7:0]  select_timeout_vicinity;
	reg [7:0]  protocol_config_three;
	reg [7:0]  protocol_config_four;
	reg [7:0]  receive_threshold;
	reg [7:0]  receive_guard_wait;
	reg [15:0] rf_timeout_pair;
	reg [7:0]  cond [0:3];
	reg [7:0]  user_scratch_area [0:111];
	reg [4:0]  state;
	reg [7:0]  unit_left;
	reg [15:0] cyc_left;
	reg [15:0] slice_left;
	reg [2:0]  cur_op;
	reg [2:0]  cur_tag;
	reg [7:0]  rd_next;
	// Field reset is applied only by these operations
	function uses_field_reset;
		input [2:0] op;
		begin
			uses_field_reset = (op == `RPCB_OP_SELECT) ||
				(op == `RPCB_OP_CONT_READ) ||
				(op == `RPCB_OP_MULTI_LIST) ||
				(op == `RPCB_OP_MULTI_SEL);
		end
	endfunction

	// Select, continuous read, multi-tag, high-speed select except short-range, and type A login take the per-tag time-out
	function is_select_op;
		input [2:0] op;
		input [2:0] tag;
		begin
			case (op)
			`RPCB_OP_SELECT, `RPCB_OP_CONT_READ, `RPCB_OP_MULTI_LIST,
			`RPCB_OP_MULTI_SEL: is_select_op = 1'b1;
			`RPCB_OP_HS_SELECT: is_select_op = (tag != `RPCB_TAG_SR);
			`RPCB_OP_LOGIN:     is_select_op = (tag == `RPCB_TAG_A);
			default:            is_select_op = 1'b0;
			endcase
		end
	endfunction

	function [15:0] pick_timeout;
		input [2:0] op;
		input [2:0] tag;
		begin
			if (!is_select_op(op, tag))
				pick_timeout = (rf_timeout_pair == 16'h0000) ?
					16'h0001 : rf_timeout_pair;
			else
				case (tag)
				`RPCB_TAG_A:  pick_timeout = {8'h00,
					select_timeout_type_a}; // [RULE6]
				`RPCB_TAG_B:  pick_timeout = {8'h00,
					select_timeout_type_b}; // [RULE7]
				`RPCB_TAG_SR: pick_timeout = {8'h00,
					select_timeout_short_range}; // [RULE8]
				default:      pick_timeout = {8'h00,
					select_timeout_vicinity}; // [RULE9]
				endcase
		end
	endfunction
	wire addr_user = (reg_addr >= `RPCB_OFF_USER_LO) &&
		(reg_addr <= `RPCB_OFF_USER_HI);
	wire [6:0] user_idx = reg_addr[6:0];

	////////////////////////////////////////////////////////////////////////
	// Register writes
	always @(posedge clk) begin
		if (!rstn) begin
			field_off_duration         <= `RPCB_RST_FIELD_OFF; // [RULE1]
			field_recovery_duration    <= `RPCB_RST_RECOVERY; // [RULE2]
			application_family_filter  <= `RPCB_RST_FAMILY;
			select_timeout_type_a      <= `RPCB_RST_TMO;
			select_timeout_type_b      <= `RPCB_RST_TMO;
			select_timeout_short_range <= `RPCB_RST_TMO;
			select_timeout_vicinity    <= `RPCB_RST_TMO;
			protocol_config_three      <= `RPCB_RST_CFG;
			protocol_config_four       <= `RPCB_RST_CFG;
			receive_threshold          <= `RPCB_RST_THRESH;
			receive_guard_wait         <= `RPCB_RST_CFG;
			card_logical_number        <= `RPCB_RST_CFG; // [RULE20]
			page_start                 <= `RPCB_RST_CFG;
			page_count                 <= `RPCB_RST_CFG;
			rf_timeout_pair            <= `RPCB_RST_TMR;
			cond[0]                    <= `RPCB_RST_COND0; // [RULE22]
			cond[1]                    <= `RPCB_RST_COND_N;
			cond[2]                    <= `RPCB_RST_COND_N;
			cond[3]                    <= `RPCB_RST_COND_N;
		end else if (reg_wr) begin
			case (reg_addr)
			`RPCB_OFF_FIELD_OFF:   field_off_duration <= reg_wdata;
			`RPCB_OFF_RECOVERY:    field_recovery_duration <= reg_wdata;
			`RPCB_OFF_FAMILY:      application_family_filter <= reg_wdata;
			`RPCB_OFF_TMO_A:       select_timeout_type_a <= reg_wdata;
			`RPCB_OFF_TMO_B:       select_timeout_type_b <= reg_wdata;
			`RPCB_OFF_TMO_SR:      select_timeout_short_range <= reg_wdata;
			`RPCB_OFF_TMO_V:       select_timeout_vicinity <= reg_wdata;
			`RPCB_OFF_CFG3:        protocol_config_three <=
				reg_wdata & `RPCB_CFG3_MASK; // [RULE23]
			`RPCB_OFF_CFG4:        protocol_config_four <=
				reg_wdata & `RPCB_CFG4_MASK; // [RULE23]
			`RPCB_OFF_PAGE_START:  page_start <= reg_wdata;
			`RPCB_OFF_PAGE_COUNT:  page_count <= reg_wdata;
			`RPCB_OFF_THRESH:      receive_threshold <= reg_wdata;
			`RPCB_OFF_CARD_NUM:    card_logical_number <= reg_wdata;
			`RPCB_OFF_GUARD_WAIT:  receive_guard_wait <= reg_wdata;
			`RPCB_OFF_TMR_LO:      rf_timeout_pair[15:8] <= reg_wdata;
			`RPCB_OFF_TMR_HI:      rf_timeout_pair[7:0] <= reg_wdata;
			`RPCB_OFF_COND0:       cond[0] <= reg_wdata;
			`RPCB_OFF_COND1:       cond[1] <= reg_wdata;
			`RPCB_OFF_COND2:       cond[2] <= reg_wdata;
			`RPCB_OFF_COND3:       cond[3] <= reg_wdata;
			default: ;
			endcase
		end
	end

	// Scratch area has no reset; a RAM would not have one either
	always @(posedge clk) begin
		if (reg_wr && addr_user)
			user_scratch_area[user_idx] <= reg_wdata;
	end

	////////////////////////////////////////////////////////////////////////
	// Register reads, one cycle latency
	always @* begin
		case (reg_addr)
		`RPCB_OFF_FIELD_OFF:   rd_next = field_off_duration;
		`RPCB_OFF_RECOVERY:    rd_next = field_recovery_duration;
		`RPCB_OFF_FAMILY:      rd_next = application_family_filter;
		`RPCB_OFF_TMO_A:       rd_next = select_timeout_type_a;
		`RPCB_OFF_TMO_B:       rd_next = select_timeout_type_b;
		`RPCB_OFF_TMO_SR:      rd_next = select_timeout_short_range;
		`RPCB_OFF_TMO_V:       rd_next = select_timeout_vicinity;
		`RPCB_OFF_CFG3:        rd_next = protocol_config_three;
		`RPCB_OFF_CFG4:        rd_next = protocol_config_four;
		`RPCB_OFF_PAGE_START:  rd_next = page_start;
		`RPCB_OFF_PAGE_COUNT:  rd_next = page_count;
		`RPCB_OFF_THRESH:      rd_next = receive_threshold;
		`RPCB_OFF_CARD_NUM:    rd_next = card_logical_number;
		`RPCB_OFF_GUARD_WAIT:  rd_next = receive_guard_wait;
		`RPCB_OFF_TMR_LO:      rd_next = rf_timeout_pair[15:8];
		`RPCB_OFF_TMR_HI:      rd_next = rf_timeout_pair[7:0];
		`RPCB_OFF_COND0:       rd_next = cond[0];
		`RPCB_OFF_COND1:       rd_next = cond[1];
		`RPCB_OFF_COND2:       rd_next = cond[2];
		`RPCB_OFF_COND3:       rd_next = cond[3];
		default:
			rd_next = addr_user ? user_scratch_area[user_idx] : 8'h00;
		endcase
	end

	always @(posedge clk) begin
		if (!rstn) begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd)
				reg_rdata <= rd_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Field reset and communication time-out sequencer
	always @(posedge clk) begin
		if (!rstn) begin
			state      <= ST_IDLE;
			unit_left  <= 8'h00;
			cyc_left   <= 16'h0000;
			slice_left <= 16'h0000;
			cur_op     <= `RPCB_OP_OTHER;
			cur_tag    <= `RPCB_TAG_A;
			field_on   <= 1'b1;
			rx_enable  <= 1'b0;
			op_busy    <= 1'b0;
			op_timeout <= 1'b0;
			op_done    <= 1'b0;
		end else begin
			op_done <= 1'b0;
			case (state)
			ST_IDLE: begin
				rx_enable <= 1'b0;
				if (op_start) begin
					cur_op     <= op_code;
					cur_tag    <= op_tag;
					op_busy    <= 1'b1;
					op_timeout <= 1'b0;
					cyc_left   <= MS_CYC[15:0] - 16'h0001;
					if (uses_field_reset(op_code)) begin // [RULE3]
						field_on  <= 1'b0;
						unit_left <= field_off_duration; // [RULE1]
						state     <= ST_OFF;
					end else begin
						slice_left <= pick_timeout(op_code, op_tag);
						cyc_left   <= SLICE_CYC[15:0] - 16'h0001;
						state      <= ST_COMM;
					end
				end
			end
			ST_OFF: begin
				if (unit_left == 8'h00) begin
					field_on  <= 1'b1;
					unit_left <= field_recovery_duration; // [RULE2]
					cyc_left  <= MS_CYC[15:0] - 16'h0001;
					state     <= ST_REC;
				end else if (cyc_left == 16'h0000) begin
					cyc_left  <= MS_CYC[15:0] - 16'h0001;
					unit_left <= unit_left - 8'h01;
				end else
					cyc_left <= cyc_left - 16'h0001;
			end
			ST_REC: begin
				if (unit_left == 8'h00) begin
					slice_left <= pick_timeout(cur_op, cur_tag);
					cyc_left   <= SLICE_CYC[15:0] - 16'h0001;
					state      <= ST_COMM;
				end else if (cyc_left == 16'h0000) begin
					cyc_left  <= MS_CYC[15:0] - 16'h0001;
					unit_left <= unit_left - 8'h01;
				end else
					cyc_left <= cyc_left - 16'h0001;
			end
			ST_COMM: begin
				rx_enable <= 1'b1;
				if (op_rx_done) begin
					state <= ST_DONE;
				end else if (slice_left == 16'h0000) begin
					op_timeout <= 1'b1;
					state      <= ST_DONE;
				end else if (cyc_left == 16'h0000) begin
					cyc_left   <= SLICE_CYC[15:0] - 16'h0001;
					slice_left <= slice_left - 16'h0001;
				end else
					cyc_left <= cyc_left - 16'h0001;
			end
			ST_DONE: begin
				rx_enable <= 1'b0;
				op_busy   <= 1'b0;
				op_done   <= 1'b1;
				state     <= ST_IDLE;
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered decode of the flags for the protocol engine
	always @(posedge clk) begin
		if (!rstn) begin
			family_enable           <= 1'b0;
			family_value            <= 8'h00;
			min_signal_level        <= 4'h0;
			collision_level         <= 4'h0;
			drive_conductance       <= 8'h00;
			guard_wait_cycles       <= 8'h00;
			guard_predefined        <= 1'b1;
			rf_timeout_override     <= 1'b0;
			cont_read_memory        <= 1'b0;
			ignore_missing_rx_start <= 1'b0;
			ignore_rx_guard_error   <= 1'b0;
			ignore_missing_rx_end   <= 1'b0;
			ext_id_request_answer   <= 1'b0;
			ext_id_append_sak       <= 1'b0;
			skip_write_readback     <= 1'b0;
			use_wakeup              <= 1'b0;
			hs_select_append_card   <= 1'b0;
			transfer_huge_data      <= 1'b0;
		end else begin
			family_enable <= (application_family_filter != 8'h00) &&
				((op_tag == `RPCB_TAG_B) ||
				(op_tag == `RPCB_TAG_V)); // [RULE4] [RULE5]
			family_value     <= application_family_filter; // [RULE4]
			min_signal_level <= receive_threshold[7:4]; // [RULE15]
			collision_level  <= receive_threshold[3:0]; // [RULE15]
			drive_conductance <= cond[cond_sel]; // [RULE22]
			guard_wait_cycles <= receive_guard_wait; // [RULE21]
			guard_predefined  <= (receive_guard_wait == 8'h00); // [RULE21]
			rf_timeout_override <=
				protocol_config_three[`RPCB_C3_NO_AUTO_TMO]; // [RULE10]
			cont_read_memory <=
				protocol_config_three[`RPCB_C3_PAGE_READ]; // [RULE11]
			ignore_missing_rx_start <=
				protocol_config_three[`RPCB_C3_NO_RX_SOF]; // [RULE12]
			ignore_rx_guard_error <=
				protocol_config_three[`RPCB_C3_NO_RX_EGT]; // [RULE12]
			ignore_missing_rx_end <=
				protocol_config_three[`RPCB_C3_NO_RX_EOF]; // [RULE12]
			ext_id_request_answer <=
				protocol_config_three[`RPCB_C3_REQ_EXT_ID]; // [RULE13]
			ext_id_append_sak <=
				protocol_config_three[`RPCB_C3_SAK_EXT_ID]; // [RULE14]
			skip_write_readback <=
				protocol_config_four[`RPCB_C4_NO_READBACK]; // [RULE16]
			use_wakeup <=
				protocol_config_four[`RPCB_C4_WAKEUP]; // [RULE17]
			hs_select_append_card <=
				protocol_config_four[`RPCB_C4_CARD_EXT_ID]; // [RULE18]
			transfer_huge_data <=
				protocol_config_four[`RPCB_C4_HUGE_DATA]; // [RULE19]
		end
	end

endmodule

// >>> dv/rpcb_bank_checker.sv
// Port checker for the protocol configuration bank
`timescale 1ns/1ps
module rpcb_bank_checker #(
	parameter MS_CYC    = 40000,
	parameter SLICE_CYC = 12000
) (
	// Clock and reset
	input wire       clk,
	input wire       rstn,
	// Register port
	input wire       reg_wr,
	input wire       reg_rd,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire       reg_rvalid,
	// Operation port
	input wire       op_start,
	input wire [2:0] op_tag,
	input wire       op_rx_done,
	input wire       op_busy,
	input wire       op_timeout,
	input wire       op_done,
	// Controls
	input wire       field_on,
	input wire       rx_enable,
	input wire       family_enable,
	input wire [7:0] family_value,
	input wire [3:0] min_signal_level,
	input wire [3:0] collision_level,
	input wire [7:0] guard_wait_cycles,
	input wire       guard_predefined
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	AST_RVALID: assert property (reg_rvalid == $past(reg_rd))
		else $error("read answer not one cycle after read");
	AST_THRESH: assert property (reg_wr && reg_addr == 8'h1E |->
		##2 {min_signal_level, collision_level} == $past(reg_wdata, 2))
		else $error("threshold nibbles wrong after write");
	AST_FAMILY: assert property (family_enable ==
		(family_value != 8'h00 && ($past(op_tag) == 3'd1 ||
		$past(op_tag) == 3'd3)))
		else $error("family filter gating wrong");
	AST_GUARD: assert property (guard_predefined ==
		(guard_wait_cycles == 8'h00))
		else $error("predefined guard flag wrong");
	AST_FIELD_BUSY: assert property (!field_on |-> op_busy)
		else $error("field off outside an operation");
	AST_RX_FIELD: assert property (rx_enable |-> field_on && op_busy)
		else $error("receiver open without field");
	AST_RX_DONE: assert property (rx_enable && op_rx_done |-> ##2 op_done)
		else $error("answer did not end operation");
	AST_DONE: assert property (op_done |-> !op_busy && $past(op_busy)
		##1 !op_done)
		else $error("done pulse malformed");
	AST_START: assert property (op_start && !op_busy && !op_done |=>
		op_busy && !op_timeout)
		else $error("start not taken");
	AST_TMO_HOLD: assert property (op_timeout && !op_start |=> op_timeout)
		else $error("time-out flag dropped early");

	cover property (op_timeout && op_done);
	cover property (rx_enable && op_rx_done);
	cover property ($fell(field_on));
endmodule

bind rpcb_bank rpcb_bank_checker #(.MS_CYC(MS_CYC), .SLICE_CYC(SLICE_CYC))
	i_rpcb_bank_checker (.clk(clk), .rstn(rstn), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_rvalid(reg_rvalid), .op_start(op_start), .op_tag(op_tag),
	.op_rx_done(op_rx_done), .op_busy(op_busy), .op_timeout(op_timeout),
	.op_done(op_done), .field_on(field_on), .rx_enable(rx_enable),
	.family_enable(family_enable), .family_value(family_value),
	.min_signal_level(min_signal_level),
	.collision_level(collision_level),
	.guard_wait_cycles(guard_wait_cycles),
	.guard_predefined(guard_predefined));

// >>> dv/rpcb_engine_model.sv
// Far-side protocol engine model answering the receive window
`timescale 1ns/1ps
module rpcb_engine_model (
	// Clock and reset
	input  wire       clk,
	input  wire       rstn,
	// Bench control
	input  wire       answer,
	input  wire [7:0] delay,
	// Bank side
	input  wire       rx_enable,
	output logic      op_rx_done
);
	logic [7:0] cnt;
	// A silent tag never answers, so the bank must end on its time-out
	always @(posedge clk) begin
		if (!rstn || !rx_enable) begin
			cnt        <= 8'h00;
			op_rx_done <= 1'b0;
		end else begin
			cnt        <= cnt + 8'h01;
			op_rx_done <= answer && cnt == delay;
		end
	end
endmodule

// >>> dv/rpcb_bank_test.sv
// Self-checking bench for the protocol configuration bank
`timescale 1ns/1ps
module rpcb_bank_test;
	localparam MS = 4;
	localparam SL = 3;
	logic       clk = 1'b0;
	logic       rstn = 1'b0;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic       op_start = 1'b0;
	logic [2:0] op_code = 3'd7;
	logic [2:0] op_tag = 3'd0;
	logic [1:0] cond_sel = 2'd0;
	logic       answer = 1'b0;
	logic [7:0] delay = 8'h02;
	wire  [7:0] reg_rdata, drive_conductance;
	wire  [3:0] min_sig, coll;
	wire        reg_rvalid, op_busy, op_timeout, op_done, op_rx_done;
	wire        field_on, rx_enable, family_enable, guard_predefined;
	wire  [7:0] c3;
	wire  [3:0] c4;
	wire  [7:0] fam_v, gwc, pg_s, pg_c, cln;
	int         n_errors = 0;
	int         checked = 0;
	logic [7:0] ra [19] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A,
		8'h1B, 8'h1D, 8'h1E, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25,
		8'h10, 8'h11, 8'h30};
	logic [7:0] rv [19] = '{8'h0A, 8'h25, 8'h00, 8'h10, 8'h10, 8'h10, 8'h10,
		8'h00, 8'h05, 8'hEB, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h03, 8'h00, 8'h00};
	logic [2:0] oc [7] = '{3'd0, 3'd1, 3'd2, 3'd3, 3'd4, 3'd5, 3'd7};
	logic [2:0] ot [7] = '{3'd0, 3'd1, 3'd2, 3'd3, 3'd1, 3'd0, 3'd3};
	int         os [7] = '{2, 3, 4, 1, 3, 2, 2};
	int         ofr [7] = '{1, 0, 1, 1, 1, 0, 0};

	rpcb_bank #(.MS_CYC(MS), .SLICE_CYC(SL)) i_rpcb_bank (.clk(clk),
		.rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .op_start(op_start), .op_code(op_code),
		.op_tag(op_tag), .op_rx_done(op_rx_done), .cond_sel(cond_sel),
		.op_busy(op_busy), .op_timeout(op_timeout), .op_done(op_done),
		.field_on(field_on), .rx_enable(rx_enable),
		.family_enable(family_enable), .family_value(fam_v),
		.min_signal_level(min_sig), .collision_level(coll),
		.drive_conductance(drive_conductance), .guard_wait_cycles(gwc),
		.guard_predefined(guard_predefined),
		.rf_timeout_override(c3[0]), .cont_read_memory(c3[2]),
		.page_start(pg_s), .page_count(pg_c),
		.ignore_missing_rx_start(c3[3]),
		.ignore_rx_guard_error(c3[4]), .ignore_missing_rx_end(c3[5]),
		.ext_id_request_answer(c3[6]), .ext_id_append_sak(c3[7]),
		.skip_write_readback(c4[0]), .use_wakeup(c4[1]),
		.hs_select_append_card(c4[2]), .transfer_huge_data(c4[3]),
		.card_logical_number(cln));
	assign c3[1] = 1'b0;

	rpcb_engine_model i_rpcb_engine_model (.clk(clk), .rstn(rstn),
		.answer(answer), .delay(delay), .rx_enable(rx_enable),
		.op_rx_done(op_rx_done));

	always #12.5 clk = ~clk;

	////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] got,
		input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_range(input string what, input int got,
		input int lo, input int hi);
		checked++;
		if (got < lo || got > hi) begin
			n_errors++;
			$display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo,
				hi, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
		repeat (2) @(negedge clk);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk);
		reg_rd = 1'b0;
		chk("reg_rvalid", reg_rvalid, 8'h01);
		chk("reg_rdata", reg_rdata, exp);
	endtask

	// Counts field-off, recovery and receive cycles up to the done pulse
	task automatic run_op(input int i, output int off_c, output int rec_c,
		output int rx_c);
		int n;
		off_c = 0;
		rec_c = 0;
		rx_c = 0;
		@(negedge clk);
		op_code = oc[i];
		op_tag = ot[i];
		op_start = 1'b1;
		@(negedge clk);
		op_start = 1'b0;
		for (n = 0; n < 4000 && op_done !== 1'b1; n++) begin
			if (field_on !== 1'b1)
				off_c++;
			else if (rx_c == 0 && off_c > 0)
				rec_c++;
			if (rx_enable === 1'b1)
				rx_c++;
			@(negedge clk);
		end
		if (n == 4000) begin
			n_errors++;
			complete_run();
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset_values();
		for (int i = 0; i < 19; i++)
			rdc(ra[i], rv[i]);
		chk("guard_predefined", guard_predefined, 8'h01);
	endtask

	task automatic t_flags();
		wr(8'h1B, 8'hFF);
		rdc(8'h1B, 8'hFD);
		chk("config three flags", c3, 8'hFD);
		wr(8'h20, 8'hFF);
		rdc(8'h20, 8'h0F);
		chk("config four flags", {4'h0, c4}, 8'h0F);
		wr(8'h1B, 8'h00);
		wr(8'h20, 8'h00);
		chk("config three cleared", c3, 8'h00);
		chk("config four cleared", {4'h0, c4}, 8'h00);
		wr(8'h1E, 8'h5C);
		chk("threshold nibbles", {min_sig, coll}, 8'h5C);
		wr(8'h22, 8'h07);
		chk("guard_wait_cycles", gwc, 8'h07);
		chk("guard_predefined", guard_predefined, 8'h00);
		wr(8'h22, 8'h00);
		chk("guard_predefined", guard_predefined, 8'h01);
		wr(8'h80, 8'hA5);
		wr(8'hEF, 8'h3C);
		rdc(8'h80, 8'hA5);
		rdc(8'hEF, 8'h3C);
		wr(8'h1C, 8'h12);
		wr(8'h1F, 8'h34);
		rdc(8'h1C, 8'h12);
		rdc(8'h1F, 8'h34);
		chk("page_start", pg_s, 8'h12);
		chk("page_count", pg_c, 8'h34);
		wr(8'h21, 8'h01);
		rdc(8'h21, 8'h01);
		chk("card_logical_number", cln, 8'h01);
		wr(8'h21, 8'h00);
		chk("card_logical_number", cln, 8'h00);
	endtask

	task automatic t_family();
		wr(8'h16, 8'h5A);
		for (int t = 0; t < 4; t++) begin
			op_tag = t[2:0];
			repeat (3) @(negedge clk);
			chk("family_enable", family_enable, (t == 1 || t == 3));
		end
		chk("family_value", fam_v, 8'h5A);
		wr(8'h16, 8'h00);
		chk("family_enable off", family_enable, 8'h00);
		chk("family_value off", fam_v, 8'h00);
	endtask

	task automatic t_conductance();
		wr(8'h23, 8'h11);
		wr(8'h24, 8'h22);
		wr(8'h25, 8'h33);
		for (int c = 0; c < 4; c++) begin
			cond_sel = c[1:0];
			repeat (3) @(negedge clk);
			chk("drive_conductance", drive_conductance,
				c == 0 ? 8'h05 : {c[3:0], c[3:0]});
		end
	endtask

	// Silent tag: every operation must end on its own time-out
	task automatic t_ops();
		int f, r, x;
		wr(8'h14, 8'h03);
		wr(8'h15, 8'h02);
		wr(8'h17, 8'h02);
		wr(8'h18, 8'h03);
		wr(8'h19, 8'h04);
		wr(8'h1A, 8'h01);
		wr(8'h10, 8'h00);
		wr(8'h11, 8'h02);
		for (int i = 0; i < 7; i++) begin
			run_op(i, f, r, x);
			chk("op_timeout", op_timeout, 8'h01);
			chk_range("comm cycles", x, os[i] * SL - 1, os[i] * SL + 3);
			chk_range("field off", f, ofr[i] * 3 * MS, ofr[i] * (4 * MS + 2));
			chk_range("recovery", r, ofr[i] * 2 * MS, ofr[i] * (3 * MS + 2));
		end
	endtask

	task automatic t_answer();
		int f, r, x;
		answer = 1'b1;
		run_op(0, f, r, x);
		chk("op_timeout", op_timeout, 8'h00);
		chk_range("comm cycles", x, 1, 6);
		answer = 1'b0;
	endtask

	initial begin
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		t_reset_values();
		t_flags();
		t_family();
		t_conductance();
		t_ops();
		t_answer();
		complete_run();
	end
endmodule
